/* File: logic/sao_top.sv */
`timescale 1ns/1ps
`default_nettype none
module sao_top (
    input  wire logic                      ref_clk,
    input  wire logic                      rstn,
    input  wire logic                      cs_n,
    input  wire logic                      read_conv,
    input  wire logic                      clock_source_sel,
    input  wire logic                      serial_bit_clock_in,
    input  wire logic                      chain_in,
    input  wire logic                      byte_sel,
    input  wire logic [sao_pkg::RES_W-1:0] conv_result,
    output logic                           busy_n,
    output logic [sao_pkg::BYTE_W-1:0]     parallel_byte_bus,
    output logic                           parallel_byte_bus_oe_n,
    output logic                           serial_out,
    output logic                           serial_bit_clock_out,
    output logic                           serial_bit_clock_oe_n,
    output logic                           load_collision
);
    localparam int DCLK_LO = 60;
    localparam int DCLK_HI = 80;

    logic [5:0]                    pins_s;
    logic                          cs_n_s;
    logic                          rc_s;
    logic                          sel_s;
    logic                          dclk_s;
    logic                          chain_s;
    logic                          byte_s;
    logic                          dclk_q;
    logic                          start_q;
    logic                          start_cond;
    logic                          start_acc;
    sao_pkg::sao_conv_state_t      state;
    logic [sao_pkg::CNT_W-1:0]     conv_cnt;
    logic                          load;
    logic                          read_en;
    logic                          ext_en;
    logic                          ext_rise;
    logic                          ext_first;
    logic                          ext_shift;
    logic                          tag_q;
    logic                          tag_first;
    logic                          int_mode;
    logic                          int_first;
    logic                          int_fall;
    logic                          int_done;
    logic                          collide;
    logic [sao_pkg::RES_W-1:0]     out_reg;

    // every pin except conv_result passes two flip-flops before use
    sao_sync #(
        .W (6)
    ) u_sync (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .d       ({cs_n, read_conv, clock_source_sel,
                   serial_bit_clock_in, chain_in, byte_sel}),
        .q       (pins_s)
    );

    assign cs_n_s  = pins_s[5];
    assign rc_s    = pins_s[4];
    assign sel_s   = pins_s[3];
    assign dclk_s  = pins_s[2];
    assign chain_s = pins_s[1];
    assign byte_s  = pins_s[0];

    assign int_mode   = !sel_s;
    assign read_en    = !cs_n_s && rc_s;
    assign ext_en     = read_en && sel_s;
    assign ext_rise   = dclk_s && !dclk_q;
    assign start_cond = !cs_n_s && !rc_s;
    // only a fresh command while idle is taken
    assign start_acc  = start_cond && !start_q && busy_n;
    assign load       = (state == sao_pkg::SAO_CV_RUN)
                        && (conv_cnt == sao_pkg::LOAD_CYC);
    assign collide    = load && ext_en && dclk_s;
    // the first external rise presents the MSB without shifting
    assign ext_shift  = ext_rise && ext_en && !ext_first;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            dclk_q  <= 1'b0;
            // synced pins read low out of reset: no false start
            start_q <= 1'b1;
        end else begin
            dclk_q  <= dclk_s;
            start_q <= start_cond;
        end
    end

    // conversion timing; the external clock never times it
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state    <= sao_pkg::SAO_CV_IDLE;
            conv_cnt <= '0;
        end else begin
            case (state)
                sao_pkg::SAO_CV_IDLE: begin
                    conv_cnt <= '0;
                    if (start_acc) begin
                        state <= sao_pkg::SAO_CV_RUN;
                    end
                end
                sao_pkg::SAO_CV_RUN: begin
                    conv_cnt <= conv_cnt + 1'b1;
                    if (conv_cnt == sao_pkg::CONV_CYC - 1'b1) begin
                        state <= sao_pkg::SAO_CV_IDLE;
                    end
                end
                default: begin
                    state <= sao_pkg::SAO_CV_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            busy_n <= 1'b1;
        end else if (start_acc) begin
            busy_n <= 1'b0;
        end else if (state == sao_pkg::SAO_CV_RUN
                     && conv_cnt == sao_pkg::CONV_CYC - 1'b1) begin
            busy_n <= 1'b1;
        end
    end

    sao_dclk_gen u_dclk (
        .ref_clk    (ref_clk),
        .rstn       (rstn),
        .start      (start_acc && int_mode),
        .dclk       (serial_bit_clock_out),
        .first_rise (int_first),
        .fall       (int_fall),
        .done       (int_done)
    );

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            serial_bit_clock_oe_n <= 1'b1;
        end else begin
            serial_bit_clock_oe_n <= sel_s;
        end
    end

    // external chain bits taken on each rise, inserted on the next shift; internal one taken on the first rise
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            tag_q     <= 1'b0;
            tag_first <= 1'b0;
            ext_first <= 1'b1;
        end else begin
            if (ext_rise && ext_en) begin
                tag_q     <= chain_s;
                ext_first <= 1'b0;
            end
            if (load) begin
                ext_first <= 1'b1;
            end
            if (int_first) begin
                tag_first <= chain_s;
            end
        end
    end

    // output register: reload, internal shift or external shift
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            out_reg <= sao_pkg::RESULT_RST;
        end else if (collide) begin
            // reload clashes with a high clock: the MSB is lost
            out_reg <= {conv_result[sao_pkg::RES_W-2:0], tag_q};
        end else if (load) begin
            out_reg <= conv_result;
        end else if (int_fall) begin
            out_reg <= {out_reg[sao_pkg::RES_W-2:0], tag_first};
        end else if (ext_shift) begin
            out_reg <= {out_reg[sao_pkg::RES_W-2:0], tag_q};
        end
    end

    // steps to the next bit only after an internal falling edge or an external rising edge, so stable over both
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            serial_out <= 1'b0;
        end else if (int_mode && int_done) begin
            serial_out <= tag_first;
        end else begin
            serial_out <= out_reg[sao_pkg::RES_W-1];
        end
    end

    // parallel reads look at the register and never shift it
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            parallel_byte_bus      <= '0;
            parallel_byte_bus_oe_n <= 1'b1;
        end else begin
            parallel_byte_bus_oe_n <= !read_en;
            parallel_byte_bus      <= byte_s
                ? out_reg[sao_pkg::BYTE_W-1:0]
                : out_reg[sao_pkg::RES_W-1:sao_pkg::BYTE_W];
        end
    end

    // sticky until the next conversion; a new clash wins
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            load_collision <= 1'b0;
        end else if (collide) begin
            load_collision <= 1'b1;
        end else if (start_acc) begin
            load_collision <= 1'b0;
        end
    end

    chk_busy_low_start:
    assert property (@(posedge ref_clk) disable iff (!rstn)
        start_acc |=> !busy_n [*8])
    else $error("busy did not fall after conversion start");

    chk_load_hold_min:
    assert property (@(posedge ref_clk) disable iff (!rstn)
        load |-> conv_cnt >= sao_pkg::HOLD_MIN_CYC && !busy_n)
    else $error("result reloaded before the hold time");

    chk_busy_after_load:
    assert property (@(posedge ref_clk) disable iff (!rstn)
        $rose(busy_n) |-> $past(load, 3))
    else $error("busy rose without a prior reload");

    chk_cmd_ignored:
    assert property (@(posedge ref_clk) disable iff (!rstn)
        (!busy_n && start_cond && conv_cnt < sao_pkg::LOAD_CYC
         && state == sao_pkg::SAO_CV_RUN)
        |=> conv_cnt == $past(conv_cnt) + 1'b1)
    else $error("convert command restarted a running conversion");

    chk_par_drive:
    assert property (@(posedge ref_clk) disable iff (!rstn)
        read_en |=> !parallel_byte_bus_oe_n)
    else $error("byte bus not driven while selected for read");

    chk_int_clk_start:
    assert property (@(posedge ref_clk) disable iff (!rstn)
        start_acc && int_mode
        |=> !serial_bit_clock_out [*8]
            ##[DCLK_LO:DCLK_HI] serial_bit_clock_out)
    else $error("internal bit clock start delay wrong");

    chk_dclk_idle_low:
    assert property (@(posedge ref_clk) disable iff (!rstn)
        int_done && int_mode |=> !serial_bit_clock_out
                                 && serial_out == $past(tag_first))
    else $error("bit clock or tail bit wrong after 16 pulses");

    chk_ext_gated:
    assert property (@(posedge ref_clk) disable iff (!rstn)
        !ext_en && !load && !int_fall |=> $stable(out_reg))
    else $error("output register moved without a serial pulse");

    chk_msb_first:
    assert property (@(posedge ref_clk) disable iff (!rstn)
        ext_first && ext_rise && ext_en && !load && !int_fall
        |=> $stable(out_reg) && !ext_first)
    else $error("first external rise shifted the MSB away");
endmodule : sao_top
`default_nettype wire

/* File: logic/sao_pkg.sv */
`default_nettype none
package sao_pkg;
    localparam int CLK_MHZ        = 50;
    localparam int RES_W          = 16;
    localparam int BYTE_W         = 8;
    localparam int CNT_W          = 10;
    localparam int DCNT_W         = 7;
    localparam int BIT_W          = 5;

    // times in nanoseconds, and the bit-clock pulse count
    localparam int HOLD_MIN_NS    = 12000;
    localparam int CONV_NS        = 19000;
    localparam int BUSY_DLY_NS    = 60;
    localparam int DCLK_START_NS  = 1400;
    localparam int DCLK_PER_NS    = 1100;
    localparam int DCLK_BITS      = 16;

    // least times round up, others round down
    localparam logic [CNT_W-1:0] HOLD_MIN_CYC =
        CNT_W'((HOLD_MIN_NS * CLK_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] CONV_CYC =
        CNT_W'(CONV_NS * CLK_MHZ / 1000);
    localparam logic [CNT_W-1:0] BUSY_DLY_CYC =
        CNT_W'(BUSY_DLY_NS * CLK_MHZ / 1000);
    localparam logic [CNT_W-1:0] LOAD_CYC = CONV_CYC - BUSY_DLY_CYC;
    localparam logic [DCNT_W-1:0] DCLK_START_CYC =
        DCNT_W'(DCLK_START_NS * CLK_MHZ / 1000);
    localparam logic [DCNT_W-1:0] DCLK_PER_CYC =
        DCNT_W'(DCLK_PER_NS * CLK_MHZ / 1000);
    localparam logic [DCNT_W-1:0] DCLK_HIGH_CYC =
        DCNT_W'(DCLK_PER_NS * CLK_MHZ / 2000);
    localparam logic [BIT_W-1:0] DCLK_LAST_BIT = BIT_W'(DCLK_BITS - 1);

    localparam logic [RES_W-1:0] RESULT_RST = 16'h0000;

    typedef enum logic [1:0] {
        SAO_DC_IDLE,
        SAO_DC_WAIT,
        SAO_DC_HIGH,
        SAO_DC_LOW
    } sao_dclk_state_t;

    typedef enum logic {
        SAO_CV_IDLE,
        SAO_CV_RUN
    } sao_conv_state_t;
endpackage : sao_pkg
`default_nettype wire

/* File: logic/sao_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module sao_sync #(
    parameter int W = 1
) (
    input  wire logic         ref_clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule : sao_sync
`default_nettype wire

/* File: logic/sao_dclk_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module sao_dclk_gen (
    input  wire logic ref_clk,
    input  wire logic rstn,
    input  wire logic start,
    output logic      dclk,
    output logic      first_rise,
    output logic      fall,
    output logic      done
);
    sao_pkg::sao_dclk_state_t           state;
    logic [sao_pkg::DCNT_W-1:0]         cnt;
    logic [sao_pkg::BIT_W-1:0]          bits;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state      <= sao_pkg::SAO_DC_IDLE;
            cnt        <= '0;
            bits       <= '0;
            dclk       <= 1'b0;
            first_rise <= 1'b0;
            fall       <= 1'b0;
            done       <= 1'b0;
        end else begin
            first_rise <= 1'b0;
            fall       <= 1'b0;
            cnt        <= cnt + 1'b1;
            case (state)
                sao_pkg::SAO_DC_IDLE: begin
                    dclk <= 1'b0;
                    if (start) begin
                        state <= sao_pkg::SAO_DC_WAIT;
                        cnt   <= '0;
                        bits  <= '0;
                        done  <= 1'b0;
                    end
                end
                sao_pkg::SAO_DC_WAIT: begin
                    if (cnt == sao_pkg::DCLK_START_CYC - 1'b1) begin
                        state      <= sao_pkg::SAO_DC_HIGH;
                        cnt        <= '0;
                        dclk       <= 1'b1;
                        first_rise <= 1'b1;
                    end
                end
                sao_pkg::SAO_DC_HIGH: begin
                    if (cnt == sao_pkg::DCLK_HIGH_CYC - 1'b1) begin
                        state <= sao_pkg::SAO_DC_LOW;
                        cnt   <= '0;
                        dclk  <= 1'b0;
                        fall  <= 1'b1;
                        if (bits == sao_pkg::DCLK_LAST_BIT) begin
                            // tail level from the 16th fall on
                            done <= 1'b1;
                        end
                    end
                end
                sao_pkg::SAO_DC_LOW: begin
                    if (cnt == sao_pkg::DCLK_PER_CYC
                            - sao_pkg::DCLK_HIGH_CYC - 1'b1) begin
                        cnt <= '0;
                        if (bits == sao_pkg::DCLK_LAST_BIT) begin
                            // low until the next start
                            state <= sao_pkg::SAO_DC_IDLE;
                        end else begin
                            state <= sao_pkg::SAO_DC_HIGH;
                            dclk  <= 1'b1;
                            bits  <= bits + 1'b1;
                        end
                    end
                end
                default: begin
                    state <= sao_pkg::SAO_DC_IDLE;
                    dclk  <= 1'b0;
                end
            endcase
        end
    end
endmodule : sao_dclk_gen
`default_nettype wire

/* File: sim/sao_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sao_host_model (
    input  wire logic                      ref_clk,
    input  wire logic                      serial_out,
    input  wire logic [sao_pkg::BYTE_W-1:0] parallel_byte_bus,
    output logic                           cs_n,
    output logic                           read_conv,
    output logic                           clock_source_sel,
    output logic                           serial_bit_clock_in,
    output logic                           chain_in,
    output logic                           byte_sel
);
    logic hold_chain;

    initial begin
        hold_chain = 1'b1;
        cs_n = 1'b1;
        read_conv = 1'b1;
        clock_source_sel = 1'b1;
        serial_bit_clock_in = 1'b0;
        chain_in = 1'b0;
        byte_sel = 1'b0;
    end

    // chain line wanders while no frame uses it
    always @(negedge ref_clk) begin
        if (!hold_chain) chain_in <= ~chain_in;
    end

    task automatic conv_start(input logic sel, input logic chain);
        hold_chain = 1'b1;
        @(negedge ref_clk);
        clock_source_sel <= sel;
        repeat (3) @(negedge ref_clk);
        chain_in  <= chain;
        cs_n      <= 1'b0;
        read_conv <= 1'b0;
        repeat (2) @(negedge ref_clk);
        read_conv <= 1'b1;
    endtask : conv_start

    // bytes taken only once busy has risen, never in the reload window
    task automatic par_read(output logic [15:0] v);
        cs_n      <= 1'b0;
        read_conv <= 1'b1;
        byte_sel  <= 1'b0;
        repeat (5) @(negedge ref_clk);
        v[15:8] = parallel_byte_bus;
        byte_sel <= 1'b1;
        repeat (5) @(negedge ref_clk);
        v[7:0] = parallel_byte_bus;
        byte_sel <= 1'b0;
    endtask : par_read

    // 160 ns frame clock, half high; low outside frames
    task automatic ext_read(input logic en, input int n,
                            input logic [31:0] bits, output logic [31:0] got);
        hold_chain = 1'b1;
        got = 32'h0000_0000;
        cs_n      <= ~en;
        read_conv <= 1'b1;
        @(negedge ref_clk);
        for (int i = 0; i < n; i++) begin
            chain_in <= bits[i];
            @(negedge ref_clk);
            serial_bit_clock_in <= 1'b1;
            repeat (4) @(negedge ref_clk);
            serial_bit_clock_in <= 1'b0;
            repeat (3) @(negedge ref_clk);
            got[i] = serial_out;
        end
        hold_chain = 1'b0;
    endtask : ext_read
endmodule : sao_host_model
`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
    n_compared++; \
    if ((g) !== (e)) begin \
        mismatches++; \
        $display("Error %s expected %0h seen %0h", nm, e, g); \
    end \
end
module tb;
    logic                          ref_clk = 1'b0;
    logic                          rstn = 1'b0;
    logic [sao_pkg::RES_W-1:0]     conv_result = 16'h0000;
    logic                          cs_n, read_conv, clock_source_sel;
    logic                          serial_bit_clock_in, chain_in, byte_sel;
    logic                          busy_n, serial_out, load_collision;
    logic [sao_pkg::BYTE_W-1:0]    parallel_byte_bus;
    logic                          parallel_byte_bus_oe_n;
    logic                          serial_bit_clock_out, serial_bit_clock_oe_n;
    int                            mismatches = 0;
    int                            n_compared = 0;
    int                            cycles = 0;
    integer                        seed;
    logic [15:0]                   r, prev;
    logic [31:0]                   cb, got;

    sao_top dut (
        .ref_clk(ref_clk), .rstn(rstn), .cs_n(cs_n), .read_conv(read_conv),
        .clock_source_sel(clock_source_sel),
        .serial_bit_clock_in(serial_bit_clock_in), .chain_in(chain_in),
        .byte_sel(byte_sel), .conv_result(conv_result), .busy_n(busy_n),
        .parallel_byte_bus(parallel_byte_bus),
        .parallel_byte_bus_oe_n(parallel_byte_bus_oe_n),
        .serial_out(serial_out), .serial_bit_clock_out(serial_bit_clock_out),
        .serial_bit_clock_oe_n(serial_bit_clock_oe_n),
        .load_collision(load_collision)
    );

    sao_host_model host (
        .ref_clk(ref_clk), .serial_out(serial_out),
        .parallel_byte_bus(parallel_byte_bus), .cs_n(cs_n),
        .read_conv(read_conv), .clock_source_sel(clock_source_sel),
        .serial_bit_clock_in(serial_bit_clock_in), .chain_in(chain_in),
        .byte_sel(byte_sel)
    );

    always #10 ref_clk = ~ref_clk;

    function automatic logic exp_bit(input logic [15:0] res,
                                     input logic [31:0] tag, input int i);
        return (i < 16) ? res[15 - i] : tag[i - 16];
    endfunction : exp_bit

    task automatic end_of_test;
        if (mismatches == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_of_test

    task automatic run_conv(input logic sel, input logic hi, input logic ok,
                            input logic [15:0] nxt, input logic [15:0] old);
        int          lo, pulses, fc, r1, f16;
        logic        pc, chain;
        logic [15:0] bits, v;
        lo = 0;
        pulses = 0;
        fc = -1;
        r1 = -1;
        f16 = -1;
        pc = 1'b0;
        bits = 16'h0000;
        chain = 1'($random(seed));
        conv_result = nxt;
        host.conv_start(sel, chain);
        if (hi) host.serial_bit_clock_in <= 1'b1;
        for (int c = 0; c < 1200; c++) begin
            @(negedge ref_clk);
            if (!busy_n) lo++;
            if (!busy_n && fc < 0) fc = c;
            // re-formed start while busy must be ignored
            if (c == 100) host.read_conv <= 1'b0;
            if (c == 104) host.read_conv <= 1'b1;
            if (sel && ok && c == 500) begin
                `CHK("old_hi", old[15:8], parallel_byte_bus)
                `CHK("bus_oe_n", 1'b0, parallel_byte_bus_oe_n)
            end
            if (serial_bit_clock_out && !pc) begin
                if (r1 < 0) begin
                    r1 = c;
                    `CHK("clk_start", 70, c - fc)
                end
                if (pulses == 1) `CHK("clk_period", 55, c - r1)
                bits = {bits[14:0], serial_out};
                pulses++;
            end
            if (!serial_bit_clock_out && pc) begin
                `CHK("bit_at_fall", bits[0], serial_out)
                if (pulses == 16) f16 = c;
            end
            if (f16 > 0 && c >= f16 + 3)
                `CHK("chain_level", chain, serial_out)
            pc = serial_bit_clock_out;
        end
        if (hi) host.serial_bit_clock_in <= 1'b0;
        host.hold_chain = 1'b0;
        `CHK("busy_low_cycles", 950, lo)
        `CHK("bit_clk_oe_n", sel, serial_bit_clock_oe_n)
        `CHK("pulses", sel ? 0 : 16, pulses)
        if (!sel) `CHK("serial_bits", old, bits)
        `CHK("collision", hi, load_collision)
        host.par_read(v);
        if (hi) `CHK("shifted_load", nxt[14:7], v[15:8])
        else `CHK("new_result", nxt, v)
    endtask : run_conv

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            end_of_test();
        end
    end

    initial begin
        seed = 13;
        repeat (3) @(negedge ref_clk);
        rstn = 1'b1;
        `CHK("busy_n_rst", 1'b1, busy_n)
        `CHK("bus_oe_n_rst", 1'b1, parallel_byte_bus_oe_n)
        `CHK("serial_out_rst", 1'b0, serial_out)
        prev = 16'h0000;
        for (int k = 0; k < 3; k++) begin
            r = 16'($random(seed));
            if (k == 2) r = 16'hffff;
            run_conv(1'b0, 1'b0, 1'b1, r, prev);
            prev = r;
        end
        r = 16'h8001;
        run_conv(1'b1, 1'b0, 1'b1, r, prev);
        // pulses with readout disabled must not shift
        host.ext_read(1'b0, 3, 32'h0000_0000, got);
        `CHK("bus_off_n", 1'b1, parallel_byte_bus_oe_n)
        cb = $random(seed);
        host.ext_read(1'b1, 20, cb, got);
        for (int i = 0; i < 16; i++)
            `CHK("ext_msb", exp_bit(r, cb, i), got[i])
        for (int i = 16; i < 20; i++)
            `CHK("ext_tag", exp_bit(r, cb, i), got[i])
        run_conv(1'b1, 1'b1, 1'b0, 16'($random(seed)), 16'h0000);
        run_conv(1'b1, 1'b0, 1'b0, 16'($random(seed)), 16'h0000);
        end_of_test();
    end
endmodule : tb
`default_nettype wire
